// ### core/mcr_pkg.sv
/*
 * Constants shared by the platform misc control register block:
 * register indices, field positions, reset values and masks.
 * Assumes a 32-bit register slave addressed by byte offset.
 */
package mcr_pkg;
    // Register offsets; address_i carries the byte offset in the block.
    localparam logic [3:0]  IDX_SLAVE_PRESENCE  = 4'h8;
    localparam logic [3:0]  IDX_MASTER_PRESENCE = 4'ha;
    localparam logic [3:0]  IDX_PLATFORM_CTRL   = 4'hc;
    // Connection masks reported by the crossbar switch.
    localparam logic [7:0]  SLAVE_PORT_MASK     = 8'h07; // [R2] [R5] [R14]
    localparam logic [7:0]  MASTER_PORT_MASK    = 8'h05; // [R4] [R5] [R15]
    // Platform control field positions.
    localparam int          BIT_STALL_EN        = 16;
    localparam int          BIT_SPEC_DIS        = 15;
    localparam int          BIT_DATA_SPEC_EN    = 14;
    localparam int          BIT_CACHE_DIS       = 13;
    localparam int          BIT_INSTR_CACHE_DIS = 12;
    localparam int          BIT_DATA_CACHE_DIS  = 11;
    localparam int          BIT_CACHE_CLEAR     = 10;
    localparam int          BIT_ARBITRATION     = 9;
    // Bits that hold state; everything else reads zero.
    localparam logic [31:0] CTRL_STORE_MASK     = 32'h0001_fa00;
    localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;
    localparam logic [31:0] READ_UNMAPPED       = 32'h0000_0000;
endpackage : mcr_pkg

// ### core/mcr_ctrl_if.sv
/*
 * Carrier between the register file and the flash/crossbar decoder.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface mcr_ctrl_if;
    logic [31:0] ctrl_word;
    logic        clear_req;

    modport regs (output ctrl_word, output clear_req);
    modport dec  (input  ctrl_word, input  clear_req);
endinterface : mcr_ctrl_if

// ### core/mcr_flash_decode.sv
/*
 * Turns the platform control word into the registered enables seen by
 * the flash controller and crossbar switch, and the cache clear pulse.
 * Assumes the control word comes from logic on the same clock.
 */
`timescale 1ns/1ps
module mcr_flash_decode
    import mcr_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    mcr_ctrl_if.dec   ctrl,
    output logic      spec_instr_en_o,
    output logic      spec_data_en_o,
    output logic      cache_instr_en_o,
    output logic      cache_data_en_o,
    output logic      flash_busy_stall_enable_o,
    output logic      arbitration_select_o,
    output logic      cache_clear_o
);
    logic [31:0] w;
    assign w = ctrl.ctrl_word;

    // Speculation and cache enables follow the control word one cycle on.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spec_instr_en_o  <= 1'b1;
            spec_data_en_o   <= 1'b0;
            cache_instr_en_o <= 1'b1;
            cache_data_en_o  <= 1'b1;
        end else begin
            spec_instr_en_o  <= !w[BIT_SPEC_DIS];                  // [R8]
            spec_data_en_o   <= !w[BIT_SPEC_DIS] && w[BIT_DATA_SPEC_EN];
            cache_instr_en_o <= !w[BIT_CACHE_DIS]
                                && !w[BIT_INSTR_CACHE_DIS];        // [R10]
            cache_data_en_o  <= !w[BIT_CACHE_DIS]
                                && !w[BIT_DATA_CACHE_DIS];
        end
    end

    // Stall enable, arbitration policy and the clear pulse.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flash_busy_stall_enable_o <= 1'b0;
            arbitration_select_o      <= 1'b0;
            cache_clear_o             <= 1'b0;
        end else begin
            flash_busy_stall_enable_o <= w[BIT_STALL_EN];          // [R11]
            arbitration_select_o      <= w[BIT_ARBITRATION];       // [R13]
            cache_clear_o             <= ctrl.clear_req;           // [R12]
        end
    end

    property p_spec_decode;
        @(posedge clock_i) disable iff (!reset_n_i)
        ##1 spec_data_en_o == ($past(w[BIT_DATA_SPEC_EN])
            && !$past(w[BIT_SPEC_DIS]));
    endproperty
    a_spec_decode: assert property (p_spec_decode) // [R8]
        else $error("Data speculation enable does not match control.");

    property p_cache_decode;
        @(posedge clock_i) disable iff (!reset_n_i)
        w[BIT_CACHE_DIS] |=> !cache_instr_en_o && !cache_data_en_o;
    endproperty
    a_cache_decode: assert property (p_cache_decode) // [R10]
        else $error("Cache stays on while disabled.");

    property p_stall_policy;
        @(posedge clock_i) disable iff (!reset_n_i)
        ##1 flash_busy_stall_enable_o == $past(w[BIT_STALL_EN])
            && arbitration_select_o == $past(w[BIT_ARBITRATION]);
    endproperty
    a_stall_policy: assert property (p_stall_policy) // [R11] [R13]
        else $error("Stall or arbitration output does not follow control.");

    property p_reset_state;
        @(posedge clock_i) disable iff (!reset_n_i)
        (w == CTRL_RESET) |=> spec_instr_en_o && !spec_data_en_o
            && cache_instr_en_o && cache_data_en_o;
    endproperty
    a_reset_state: assert property (p_reset_state) // [R7] [R9]
        else $error("Default flash configuration is wrong.");
endmodule : mcr_flash_decode

// ### core/mcr_regs.sv
/*
 * Platform misc control register block: two read-only crossbar
 * connection masks and the platform control register, reached over
 * an Avalon-MM slave with waitrequest and one wait state per access.
 * Assumes a master on clock_i that puts the register's byte offset on
 * address_i and holds its request until it sees waitrequest low.
 */
// Contract
// R1 - Read-only 16-bit slave connection register.
// R2 - Bit n marks slave port n.
// R3 - Read-only 16-bit master connection register.
// R4 - Bit n marks master port n.
// R5 - One means present, zero means absent.
// R6 - Reserved bits read zero, ignore writes.
// R7 - Reset: speculation for instructions only.
// R8 - Speculation disable bit overrides data enable.
// R9 - Reset: cache on for both fetch types.
// R10 - Cache disable overrides per-type disables.
// R11 - Bit sixteen enables stalling while flash busy.
// R12 - Writing one clears cache, reads zero.
// R13 - Bit nine picks fixed or round-robin.
// R14 - Slave register at offset 8 reads 0007.
// R15 - Master register at offset A reads 0005.
`timescale 1ns/1ps
module mcr_regs
    import mcr_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    output logic             spec_instr_en_o,
    output logic             spec_data_en_o,
    output logic             cache_instr_en_o,
    output logic             cache_data_en_o,
    output logic             flash_busy_stall_enable_o,
    output logic             arbitration_select_o,
    output logic             cache_clear_o
);
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic        ack_reg;
    logic [31:0] readdata_reg;
    logic        clear_reg;
    logic        req;
    logic        wr_done;
    logic        ctrl_wr;
    logic        rd_first;
    logic [31:0] be_mask;

    mcr_ctrl_if ctrl_bus ();

    // Expands the byte enables into a bit mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    // True when an offset selects the platform control register.
    function automatic logic hits_ctrl(input logic [3:0] idx);
        hits_ctrl = (idx == IDX_PLATFORM_CTRL);
    endfunction : hits_ctrl

    // Read value of a register index; unmapped words read zero.
    function automatic logic [31:0] read_value(
        input logic [3:0]  idx,
        input logic [31:0] ctrl
    );
        case (idx)
            IDX_SLAVE_PRESENCE:  read_value = {24'h0, SLAVE_PORT_MASK};
            IDX_MASTER_PRESENCE: read_value = {24'h0, MASTER_PORT_MASK};
            IDX_PLATFORM_CTRL:   read_value = ctrl & CTRL_STORE_MASK;
            default:             read_value = READ_UNMAPPED;
        endcase
    endfunction : read_value

    // A request is held by the master until waitrequest drops.
    assign req      = read_i || write_i;
    assign rd_first = read_i && !ack_reg;
    assign wr_done  = write_i && ack_reg;
    assign ctrl_wr  = wr_done && hits_ctrl(address_i);
    assign be_mask  = lane_mask(byteenable_i);

    // Every access sees exactly one wait state.
    assign waitrequest_o = req && !ack_reg;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req && !ack_reg;
        end
    end

    // Read data is captured in the wait cycle and stands at the ack edge.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            readdata_reg <= 32'h0000_0000;
        end else if (rd_first) begin
            readdata_reg <= read_value(address_i, ctrl_reg); // [R1] [R3]
        end
    end
    assign readdata_o = readdata_reg;

    // Only the stored control bits take writes; the masks ignore them.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            ctrl_next = (ctrl_reg & ~(be_mask & CTRL_STORE_MASK))
                      | (writedata_i & be_mask & CTRL_STORE_MASK); // [R6]
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= CTRL_RESET;                          // [R7] [R9]
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // The clear bit is never stored; a one written makes a pulse.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= ctrl_wr && byteenable_i[1]
                         && writedata_i[BIT_CACHE_CLEAR];    // [R12]
        end
    end

    assign ctrl_bus.ctrl_word = ctrl_reg;
    assign ctrl_bus.clear_req = clear_reg;

    // Decoder drives the registered flash and crossbar controls.
    mcr_flash_decode u_decode (
        .clock_i                   (clock_i),
        .reset_n_i                 (reset_n_i),
        .ctrl                      (ctrl_bus.dec),
        .spec_instr_en_o           (spec_instr_en_o),
        .spec_data_en_o            (spec_data_en_o),
        .cache_instr_en_o          (cache_instr_en_o),
        .cache_data_en_o           (cache_data_en_o),
        .flash_busy_stall_enable_o (flash_busy_stall_enable_o),
        .arbitration_select_o      (arbitration_select_o),
        .cache_clear_o             (cache_clear_o)
    );

    // A held request is answered on the second edge.
    property p_one_wait;
        @(posedge clock_i) disable iff (!reset_n_i)
        (req && !ack_reg) ##1 req |-> !waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("Access not answered after one wait state.");

    // Each connection mask reads its fixed value at the answer.
    property p_slave_read;
        @(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o && address_i == IDX_SLAVE_PRESENCE
        |-> readdata_o == 32'h0000_0007;
    endproperty
    a_slave_read: assert property (p_slave_read) // [R1] [R2] [R5] [R14]
        else $error("Slave connection register reads wrong value.");

    property p_master_read;
        @(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o && address_i == IDX_MASTER_PRESENCE
        |-> readdata_o == 32'h0000_0005;
    endproperty
    a_master_read: assert property (p_master_read) // [R3] [R4] [R5] [R15]
        else $error("Master connection register reads wrong value.");

    // Reserved bits of the control word never hold a one.
    property p_reserved_zero;
        @(posedge clock_i) disable iff (!reset_n_i)
        (ctrl_reg & ~CTRL_STORE_MASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [R6]
        else $error("Reserved control bit holds a one.");

    // A full-word write stores every implemented control bit.
    property p_ctrl_write;
        @(posedge clock_i) disable iff (!reset_n_i)
        wr_done && address_i == IDX_PLATFORM_CTRL && byteenable_i == 4'hf
        |=> ctrl_reg == ($past(writedata_i) & CTRL_STORE_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // [R8] [R10] [R11]
        else $error("Control write did not store the written bits.");

    // A one written to the clear bit makes exactly one pulse.
    property p_clear_pulse;
        @(posedge clock_i) disable iff (!reset_n_i)
        wr_done && address_i == IDX_PLATFORM_CTRL && byteenable_i[1]
        && writedata_i[BIT_CACHE_CLEAR] |-> ##2 cache_clear_o ##1
        !cache_clear_o;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) // [R12]
        else $error("Cache clear pulse missing or too long.");

    property p_clear_reads_zero;
        @(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o |-> !readdata_o[BIT_CACHE_CLEAR];
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) // [R12]
        else $error("Cache clear bit reads back as one.");

    // Writes outside the control register leave its state alone.
    property p_ro_unchanged;
        @(posedge clock_i) disable iff (!reset_n_i)
        wr_done && address_i != IDX_PLATFORM_CTRL |=> $stable(ctrl_reg);
    endproperty
    a_ro_unchanged: assert property (p_ro_unchanged) // [R1] [R3]
        else $error("Write outside control register changed state.");

    // The policy output follows the written select bit.
    property p_policy_follow;
        @(posedge clock_i) disable iff (!reset_n_i)
        wr_done && address_i == IDX_PLATFORM_CTRL && byteenable_i[1]
        |-> ##2 arbitration_select_o
            == $past(writedata_i[BIT_ARBITRATION], 2);
    endproperty
    a_policy_follow: assert property (p_policy_follow) // [R13]
        else $error("Arbitration select does not follow write.");

    // The first edge of every request sees waitrequest high.
    property p_first_wait;
        @(posedge clock_i) disable iff (!reset_n_i)
        $rose(req) |-> waitrequest_o;
    endproperty
    a_first_wait: assert property (p_first_wait)
        else $error("Request answered without its wait state.");

    // Read data stands for the cycle after the answer.
    property p_read_hold;
        @(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o |=> $stable(readdata_o);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("Read data changed right after the answer.");

    // Reserved and clear bits of the control word always read zero.
    property p_ctrl_read_reserved;
        @(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o && hits_ctrl(address_i)
        |-> (readdata_o & ~CTRL_STORE_MASK) == 32'h0000_0000;
    endproperty
    a_ctrl_read_reserved: assert property (p_ctrl_read_reserved) // [R6] [R12]
        else $error("Control register reads a reserved one.");

    // Offsets outside the three registers read zero.
    property p_unmapped_read;
        @(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o && address_i != IDX_SLAVE_PRESENCE
        && address_i != IDX_MASTER_PRESENCE && !hits_ctrl(address_i)
        |-> readdata_o == 32'h0000_0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) // [R6]
        else $error("Unmapped offset reads a nonzero value.");

    // A write without byte lane two leaves the stall enable alone.
    property p_stall_lane;
        @(posedge clock_i) disable iff (!reset_n_i)
        ctrl_wr && !byteenable_i[2]
        |=> ctrl_reg[BIT_STALL_EN] == $past(ctrl_reg[BIT_STALL_EN]);
    endproperty
    a_stall_lane: assert property (p_stall_lane) // [R11]
        else $error("Stall enable changed by a masked byte lane.");

    // A write without byte lane one leaves the flash and policy bits.
    property p_flash_lane;
        @(posedge clock_i) disable iff (!reset_n_i)
        ctrl_wr && !byteenable_i[1]
        |=> ctrl_reg[BIT_SPEC_DIS:BIT_ARBITRATION]
            == $past(ctrl_reg[BIT_SPEC_DIS:BIT_ARBITRATION]);
    endproperty
    a_flash_lane: assert property (p_flash_lane) // [R8] [R10] [R13]
        else $error("Flash or policy bits changed by a masked lane.");

    // The clear pulse lasts a single cycle.
    property p_clear_one_cycle;
        @(posedge clock_i) disable iff (!reset_n_i)
        cache_clear_o |=> !cache_clear_o;
    endproperty
    a_clear_one_cycle: assert property (p_clear_one_cycle) // [R12]
        else $error("Cache clear pulse held for two cycles.");

    // Writing zero to the clear bit, or masking its lane, does nothing.
    property p_clear_needs_one;
        @(posedge clock_i) disable iff (!reset_n_i)
        ctrl_wr && !(byteenable_i[1] && writedata_i[BIT_CACHE_CLEAR])
        |-> ##2 !cache_clear_o;
    endproperty
    a_clear_needs_one: assert property (p_clear_needs_one) // [R12]
        else $error("Cache clear pulse without a one written.");

    // Writes to the mask registers never start a cache clear.
    property p_mask_write_quiet;
        @(posedge clock_i) disable iff (!reset_n_i)
        wr_done && !hits_ctrl(address_i) |=> !clear_reg;
    endproperty
    a_mask_write_quiet: assert property (p_mask_write_quiet) // [R1] [R3]
        else $error("Write outside control register made a clear.");

    c_read_slave: cover property (@(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o && address_i == IDX_SLAVE_PRESENCE);
    c_write_ctrl: cover property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_done && address_i == IDX_PLATFORM_CTRL);
    c_clear: cover property (@(posedge clock_i) disable iff (!reset_n_i)
        cache_clear_o);
    c_unmapped: cover property (@(posedge clock_i) disable iff (!reset_n_i)
        read_i && !waitrequest_o && address_i == 4'h0);
    c_stall_lane: cover property (@(posedge clock_i) disable iff (!reset_n_i)
        ctrl_wr && !byteenable_i[2]);
endmodule : mcr_regs

// ### testbench/test_platform_misc_control_regs.sv
/*
 * Self-checking bench for the platform misc control register block:
 * register reads and writes over Avalon-MM, decoded enables and the
 * cache clear pulse.
 * Assumes mcr_pkg and mcr_regs are compiled before this file.
 */
`timescale 1ns/1ps
module test_platform_misc_control_regs
    import mcr_pkg::*;
;
    logic        clock_i;
    logic        reset_n_i;
    logic [3:0]  address_i;
    logic        read_i;
    logic        write_i;
    logic [3:0]  byteenable_i;
    logic [31:0] writedata_i;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        spec_instr_en_o;
    logic        spec_data_en_o;
    logic        cache_instr_en_o;
    logic        cache_data_en_o;
    logic        flash_busy_stall_enable_o;
    logic        arbitration_select_o;
    logic        cache_clear_o;
    int          fails;
    int          n_compared;
    int          n_edges;

    // Device under test with every port driven or watched.
    mcr_regs dut_u (
        .clock_i                   (clock_i),
        .reset_n_i                 (reset_n_i),
        .address_i                 (address_i),
        .read_i                    (read_i),
        .write_i                   (write_i),
        .byteenable_i              (byteenable_i),
        .writedata_i               (writedata_i),
        .readdata_o                (readdata_o),
        .waitrequest_o             (waitrequest_o),
        .spec_instr_en_o           (spec_instr_en_o),
        .spec_data_en_o            (spec_data_en_o),
        .cache_instr_en_o          (cache_instr_en_o),
        .cache_data_en_o           (cache_data_en_o),
        .flash_busy_stall_enable_o (flash_busy_stall_enable_o),
        .arbitration_select_o      (arbitration_select_o),
        .cache_clear_o             (cache_clear_o)
    );

    // Free-running 40 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One bus cycle, held until waitrequest is sampled low.
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
             input logic [3:0] be, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clock_i);
        address_i    <= a;
        writedata_i  <= d;
        byteenable_i <= be;
        read_i       <= !wr;
        write_i      <= wr;
        do begin
            @(posedge clock_i);
            k++;
        end while (waitrequest_o !== 1'b0);
        q = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
        n_edges = k;
    endtask : bus

    // Counts clear pulses over n cycles.
    task pulses(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clock_i);
            if (cache_clear_o === 1'b1) c++;
        end
    endtask : pulses

    // Compares the decoded enables with what control word v implies.
    task outs(input logic [31:0] v);
        repeat (3) @(posedge clock_i);
        check("enables", {26'h0, spec_instr_en_o, spec_data_en_o,
              cache_instr_en_o, cache_data_en_o,
              flash_busy_stall_enable_o, arbitration_select_o},
              {26'h0, !v[15], !v[15] & v[14], !v[13] & !v[12],
              !v[13] & !v[11], v[16], v[9]});
    endtask : outs

    task t_reset_values;
        logic [31:0] q;
        outs(32'h0);
        bus(1'b0, IDX_PLATFORM_CTRL, 32'h0, 4'hf, q);
        check("ctrl after reset", q, 32'h0);
        $display("test reset_values done");
    endtask : t_reset_values

    task t_presence;
        logic [31:0] q;
        repeat (2) begin
            bus(1'b0, IDX_SLAVE_PRESENCE, 32'h0, 4'hf, q);
            check("slave mask", q, 32'h0000_0007);
            check("slave answer edges", n_edges, 2);
            bus(1'b0, IDX_MASTER_PRESENCE, 32'h0, 4'hf, q);
            check("master mask", q, 32'h0000_0005);
            bus(1'b1, IDX_SLAVE_PRESENCE, 32'hffff_ffff, 4'hf, q);
            bus(1'b1, IDX_MASTER_PRESENCE, 32'hffff_ffff, 4'hf, q);
        end
        $display("test presence done");
    endtask : t_presence

    // Every combination of bits 15..11, with reserved bits toggled.
    task t_ctrl_table;
        logic [31:0] v;
        logic [31:0] q;
        int          c;
        for (int i = 0; i < 32; i++) begin
            v = {i[0] ? 15'h7fff : 15'h0, i[0] ^ i[4], i[4:0], 1'b0,
                 i[1], i[2] ? 9'h1ff : 9'h0};
            bus(1'b1, IDX_PLATFORM_CTRL, v, 4'hf, q);
            pulses(8, c);
            check("no clear", c, 0);
            outs(v);
            bus(1'b0, IDX_PLATFORM_CTRL, 32'h0, 4'hf, q);
            check("ctrl readback", q,
                  {15'h0, v[16:11], 1'b0, v[9], 9'h0});
        end
        $display("test ctrl_table done");
    endtask : t_ctrl_table

    task t_clear;
        logic [31:0] q;
        int          c;
        bus(1'b1, IDX_PLATFORM_CTRL, 32'h0001_fe00, 4'hf, q);
        pulses(8, c);
        check("clear pulse", c, 1);
        bus(1'b0, IDX_PLATFORM_CTRL, 32'h0, 4'hf, q);
        check("clear reads zero", q, 32'h0001_fa00);
        bus(1'b1, IDX_PLATFORM_CTRL, 32'h0000_0400, 4'hd, q);
        pulses(8, c);
        check("clear lane off", c, 0);
        bus(1'b1, IDX_PLATFORM_CTRL, 32'h0, 4'hf, q);
        pulses(8, c);
        check("write zero", c, 0);
        $display("test clear done");
    endtask : t_clear

    task t_lanes_unmapped;
        logic [31:0] q;
        bus(1'b1, IDX_PLATFORM_CTRL, 32'hffff_ffff, 4'h4, q);
        outs(32'h0001_0000);
        bus(1'b1, 4'h4, 32'hffff_ffff, 4'hf, q);
        bus(1'b1, 4'hf, 32'hffff_ffff, 4'hf, q);
        bus(1'b1, IDX_PLATFORM_CTRL, 32'h0, 4'hb, q);
        bus(1'b0, 4'h0, 32'h0, 4'hf, q);
        check("unmapped read", q, 32'h0);
        bus(1'b0, IDX_PLATFORM_CTRL, 32'h0, 4'hf, q);
        check("ctrl kept", q, 32'h0001_0000);
        $display("test lanes_unmapped done");
    endtask : t_lanes_unmapped

    // Reset in mid-run returns the control word to its reset state.
    task t_mid_reset;
        logic [31:0] q;
        bus(1'b1, IDX_PLATFORM_CTRL, 32'h0001_fa00, 4'hf, q);
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_reset_values();
        $display("test mid_reset done");
    endtask : t_mid_reset

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial begin
        fails        = 0;
        n_compared   = 0;
        reset_n_i    = 1'b0;
        address_i    = 4'h0;
        read_i       = 1'b0;
        write_i      = 1'b0;
        byteenable_i = 4'hf;
        writedata_i  = 32'h0;
        repeat (5) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_reset_values();
        t_presence();
        t_ctrl_table();
        t_clear();
        t_lanes_unmapped();
        t_mid_reset();
        tally_and_finish();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (5000) @(posedge clock_i);
        fails++;
        tally_and_finish();
    end
endmodule : test_platform_misc_control_regs
